// file: bench/core_irq_model.sv
// Core interrupt logic model that takes the pending monitor interrupt.
`timescale 1ns/1ps
module core_irq_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic monitor_irq,
  input wire logic [3:0] ack_dly,
  output logic irq_pend_ack
);
  logic [3:0] wait_cnt;
  // The interrupt is taken ack_dly+1 cycles after it is seen, so both prompt and slow takers are tried.
  always_ff @(posedge ref_clk) begin
    if (reset || !monitor_irq || irq_pend_ack) begin
      wait_cnt <= 4'h0;
      irq_pend_ack <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      irq_pend_ack <= (wait_cnt == ack_dly);
    end
  end
endmodule

// file: bench/perf_monitor_gate_assertions.sv
// Port checks for the monitor gate.
`timescale 1ns/1ps
module perf_monitor_gate_assertions
  import perf_mon_pkg::*;
#(
  parameter int NUM_COUNTERS = DEFAULT_COUNTERS,
  parameter int COUNT_W = DEFAULT_COUNT_W,
  parameter int NUM_MSM = DEFAULT_MSM
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic user_monitor_run,
  input wire logic priv_monitor_run,
  input wire logic overflow_irq_mask,
  input wire logic irq_pend_ack,
  input wire logic [NUM_COUNTERS-1:0] event_pulse,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [DATA_W-1:0] reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic [NUM_COUNTERS-1:0] monitor_enable,
  input wire logic [NUM_COUNTERS-1:0] ext_overflow_notify,
  input wire logic halt_all_monitors,
  input wire logic monitor_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_halt_gates; halt_all_monitors |-> monitor_enable == '0; endproperty
  a_halt_gates: assert property (p_halt_gates) else $error("enable while halted");
  property p_run_gates; !user_monitor_run && !priv_monitor_run |-> monitor_enable == '0;
  endproperty
  a_run_gates: assert property (p_run_gates) else $error("enable without run");
  property p_rd_valid; reg_rd_en |=> reg_rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_rd_idle; !reg_rd_en |=> !reg_rd_valid && $stable(reg_rd_data); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data moved");
  property p_halt_sticky; halt_all_monitors && !reg_wr_en |=> halt_all_monitors; endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt dropped");
  property p_irq_mask; overflow_irq_mask |=> !monitor_irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq pended");
  property p_irq_ack; irq_pend_ack && halt_all_monitors |=> !monitor_irq; endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("irq held after ack");
  property p_irq_halt; $rose(monitor_irq) |-> halt_all_monitors; endproperty
  a_irq_halt: assert property (p_irq_halt) else $error("irq without halt");
  property p_notify; (ext_overflow_notify & ~$past(event_pulse & monitor_enable)) == '0;
  endproperty
  a_notify: assert property (p_notify) else $error("notify without event");
  property p_frozen; $past(halt_all_monitors) |-> ext_overflow_notify == '0; endproperty
  a_frozen: assert property (p_frozen) else $error("overflow while halted");
  c_irq: cover property (monitor_irq);
  c_notify: cover property (ext_overflow_notify != '0);
  c_ack: cover property (irq_pend_ack && halt_all_monitors);
endmodule

// file: bench/perf_monitor_gate_tb.sv
// Self-checking bench for the monitor gate.
`timescale 1ns/1ps
module perf_monitor_gate_tb;
  import perf_mon_pkg::*;
  localparam int N = 4;
  localparam int CW = 4;
  logic ref_clk = 0, reset = 1, up, pp, sec, msk, ack, we, re, spc, msm, halt, irq, rv;
  logic [1:0] cpl;
  logic [3:0] evp, en, ntf, dly;
  logic [7:0] idx;
  logic [63:0] wd, rdat, v, st0 = '0;
  logic [15:0] cfg[N] = '{default: '0};
  int cnt[N], err_count = 0, n_compared = 0, cyc = 0, s;
  perf_monitor_gate #(.NUM_COUNTERS(N), .COUNT_W(CW), .NUM_MSM(1)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .user_monitor_run(up), .priv_monitor_run(pp),
    .current_priv_level(cpl), .secure_user_monitors(sec), .overflow_irq_mask(msk),
    .irq_pend_ack(ack), .event_pulse(evp), .msm_irq_event(msm), .reg_wr_en(we),
    .reg_rd_en(re), .reg_space(spc), .reg_index(idx), .reg_wdata(wd), .reg_rd_data(rdat),
    .reg_rd_valid(rv), .monitor_enable(en), .ext_overflow_notify(ntf),
    .halt_all_monitors(halt), .monitor_irq(irq));
  core_irq_model u_core (.ref_clk(ref_clk), .reset(reset), .monitor_irq(irq),
    .ack_dly(dly), .irq_pend_ack(ack));
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end
  function automatic bit em(int i);
    return !st0[0] && cfg[i][cpl] && (cfg[i][6] ? pp : up);
  endfunction
  function automatic logic [63:0] sx(int c);
    return {{(64-CW){c[CW-1]}}, c[CW-1:0]};
  endfunction
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic sp, int i, logic [63:0] d);
    @(posedge ref_clk) #1;
    {we, spc, idx, wd} = {1'b1, sp, i[7:0], d};
    if (i >= 4 && sp) cnt[i-4] = d[CW-1:0];
    if (i >= 4 && !sp) cfg[i-4] = d[15:0];
    if (i == 0 && !sp) st0 = d & 64'h1f1;
    @(posedge ref_clk) #1;
    we = 0;
  endtask
  task automatic rd(logic sp, int i, logic [63:0] e, string nm);
    @(posedge ref_clk) #1;
    {re, spc, idx} = {1'b1, sp, i[7:0]};
    @(posedge ref_clk) #1;
    re = 0;
    chk("valid", 1, rv);
    chk(nm, e, rdat);
  endtask
  task automatic processor_status_word(logic [5:0] f);
    @(posedge ref_clk) #1;
    {sec, msk, up, pp, cpl} = f;
    #1;
  endtask
  task automatic pulse(logic [N-1:0] p, logic m);
    logic [N-1:0] e;
    logic [N-1:0] nt;
    @(posedge ref_clk) #1;
    nt = '0;
    for (int i = 0; i < N; i++) e[i] = em(i);
    for (int i = 0; i < N; i++) begin
      if (p[i] && e[i]) begin
        cnt[i] = (cnt[i] + 1) % (1 << CW);
        if (cnt[i] == 0) st0 |= (64'h10 << i) | cfg[i][5];
        nt[i] = (cnt[i] == 0) && cfg[i][4];
      end
    end
    if (m && !st0[0]) st0 |= 64'h101;
    {evp, msm} = {p, m};
    @(posedge ref_clk) #1;
    {evp, msm} = '0;
    chk("notify", nt, ntf);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {up, pp, sec, msk, cpl, evp, msm, we, re, spc, idx, wd} = '0;
    dly = 4'h6;
    s = $urandom(39911);
    repeat (8) @(posedge ref_clk);
    #1 reset = 0;
    for (int i = 0; i < 5; i++) rd(0, i, 0, "reset value");
    for (int k = 0; k < 24; k++) begin
      v = $urandom;
      wr(0, 4 + k % N, {57'h0, v[6:0]});
      processor_status_word({2'h0, v[11:8]});
      chk("enable", em(k % N), en[k % N]);
    end
    for (int pm = 0; pm < 2; pm++) begin
      for (int i = 0; i < N; i++) wr(0, 4 + i, pm ? 64'h4f : 64'hf);
      for (int r = 0; r < 2; r++) begin
        processor_status_word({2'h0, pm ? 1'b0 : r[0], pm ? r[0] : 1'b0, 2'h1});
        chk("group enable", {N{r[0]}}, en);
      end
    end
    $display("test gating done");
    wr(0, 4, 64'hf);
    for (int i = 0; i < 2; i++) wr(1, 4 + i, $urandom);
    for (int k = 0; k < 8; k++) begin
      processor_status_word({k[2], 3'h0, k[1:0]});
      for (int i = 0; i < 2; i++)
        rd(1, 4 + i, (cpl == 0 || (!sec && !cfg[i][6])) ? sx(cnt[i]) : 0, "data");
    end
    $display("test read protection done");
    processor_status_word(6'h08);
    wr(0, 4, 64'h1f);
    wr(1, 4, 64'hf);
    pulse(4'h1, 0);
    chk("halt", st0[0], halt);
    rd(0, 0, st0, "status");
    pulse(4'h1, 0);
    rd(1, 4, sx(cnt[0]), "count");
    wr(0, 5, 64'h2f);
    wr(1, 5, 64'hf);
    pulse(4'h2, 0);
    chk("irq", 1, irq);
    rd(0, 0, st0, "status");
    pulse(4'h3, 0);
    rd(1, 4, sx(cnt[0]), "frozen count");
    for (int t = 0; t < 20 && irq; t++) @(posedge ref_clk);
    #1;
    chk("irq after ack", 0, irq);
    wr(0, 0, 0);
    chk("halt cleared", 0, halt);
    $display("test overflow done");
    processor_status_word(6'h18);
    wr(1, 5, 64'hf);
    pulse(4'h2, 0);
    chk("masked irq", 0, irq);
    chk("masked halt", 1, halt);
    wr(0, 0, 0);
    processor_status_word(6'h08);
    dly = 4'h0;
    pulse(4'h0, 1);
    rd(0, 0, st0, "model status");
    for (int i = 0; i < 4; i++) begin
      wr(0, i, '1);
      rd(0, i, i ? 64'h0 : 64'h1f1, "status ones");
      wr(0, i, 0);
    end
    wr(1, 4, 64'hf);
    @(posedge ref_clk) #1;
    {we, spc, idx, wd, evp} = {2'h2, 8'h0, 64'h0, 4'h1};
    @(posedge ref_clk) #1;
    {we, evp} = '0;
    cnt[0] = 0;
    st0 = 64'h10;
    rd(0, 0, st0, "set beats write");
    $display("test status done");
    summarize();
  end
endmodule
bind perf_monitor_gate perf_monitor_gate_assertions #(.NUM_COUNTERS(NUM_COUNTERS),
  .COUNT_W(COUNT_W), .NUM_MSM(NUM_MSM)) u_chk (.ref_clk, .reset, .user_monitor_run,
  .priv_monitor_run, .overflow_irq_mask, .irq_pend_ack, .event_pulse, .reg_wr_en,
  .reg_rd_en, .reg_rd_data, .reg_rd_valid, .monitor_enable, .ext_overflow_notify,
  .halt_all_monitors, .monitor_irq);

// file: hw/counter_slice.sv
// One generic counter: configuration fields, the count and its wrap detection.
`timescale 1ns/1ps
module counter_slice
  import perf_mon_pkg::*;
#(
  parameter int COUNT_W = DEFAULT_COUNT_W
) (
  input wire logic ref_clk,
  input wire logic reset,
  counter_if.slice link
);
  logic [PLM_W-1:0] plm;
  logic ext_vis;
  logic irq_en;
  logic priv;
  logic [ES_W-1:0] event_sel;
  logic [COUNT_W-1:0] count;
  wire [COUNT_W:0] sum;
  wire active;
  wire step;

  //////////////////////////////////////////////////////////////////////////////

  assign active = ~link.halt & plm[link.priv_level] &
                  (priv ? link.priv_run : link.user_run);
  assign step = active & link.event_hit;
  assign sum = {1'b0, count} + {{COUNT_W{1'b0}}, 1'b1};
  // A software write to the count takes the cycle, so no wrap is reported then.
  assign link.overflow = step & sum[COUNT_W] & ~link.dat_we;
  assign link.enable = active;
  assign link.irq_en = irq_en;
  assign link.ext_vis = ext_vis;
  assign link.priv = priv;
  assign link.data_value = {{(DATA_W-COUNT_W){count[COUNT_W-1]}}, count};
  assign link.config_value = {{(DATA_W-ES_LSB-ES_W){1'b0}}, event_sel, 1'b0, priv,
                              irq_en, ext_vis, plm};

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      plm <= 4'h0;
      ext_vis <= 1'b0;
      irq_en <= 1'b0;
      priv <= 1'b0;
      event_sel <= 8'h0;
    end else if (link.cfg_we) begin
      plm <= link.wdata[PLM_LSB +: PLM_W];
      ext_vis <= link.wdata[EV_BIT];
      irq_en <= link.wdata[OI_BIT];
      priv <= link.wdata[PM_BIT];
      event_sel <= link.wdata[ES_LSB +: ES_W];
    end
  end

  // Steps up by one or loads a write, so a running count reads back smaller only after a wrap or a write.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= '0;
    end else if (link.dat_we) begin
      count <= link.wdata[COUNT_W-1:0];
    end else if (step) begin
      count <= sum[COUNT_W-1:0];
    end
  end
endmodule

// file: hw/perf_monitor_gate.sv
// Performance monitor enable gating, read protection and overflow status.
// Function
// - Count only when not halted, level mask bit set, and matching run bit set.
// - Select bit zero makes a user monitor readable by non-privileged code.
// - Secure user monitors keep counting but read zero to non-privileged code.
// - Privileged monitors return value only at level zero, otherwise zero.
// - Level zero always reads value; higher levels need secure and select both zero.
// - User monitors start and stop together with the user run bit.
// - Privileged monitors start and stop together with the privileged run bit.
// - Running counters are readable and read back smaller only after a wrap or a software write.
// - Moves take index and value from registers; moves out need no serialization.
// - Four status words hold 256 bits; counter i maps to word i/64 bit i%64.
// - Interrupting overflow sets its status bit, raises interrupt and sets halt.
// - Non-interrupting overflow sets only its status bit; counting continues.
// - Mask bit set blocks pending the interrupt; clear lets it pend.
// - Word zero bit 0 is halt, bits 3:1 ignored, bits 63:4 overflow.
// - Halt stops counting and freezes overflow bits; writing zero resumes.
// - Overflow is a carry out of the top implemented count bit.
// - Overflow and halt bits are sticky; only software clears them.
// - Status bits of unimplemented monitors read zero and ignore writes.
`timescale 1ns/1ps
module perf_monitor_gate
  import perf_mon_pkg::*;
#(
  parameter int NUM_COUNTERS = DEFAULT_COUNTERS,
  parameter int COUNT_W = DEFAULT_COUNT_W,
  parameter int NUM_MSM = DEFAULT_MSM
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic user_monitor_run,
  input wire logic priv_monitor_run,
  input wire logic [PRIV_LEVEL_W-1:0] current_priv_level,
  input wire logic secure_user_monitors,
  input wire logic overflow_irq_mask,
  input wire logic irq_pend_ack,
  input wire logic [NUM_COUNTERS-1:0] event_pulse,
  input wire logic [NUM_MSM-1:0] msm_irq_event,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic reg_space,
  input wire logic [INDEX_W-1:0] reg_index,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rd_data,
  output logic reg_rd_valid,
  output logic [NUM_COUNTERS-1:0] monitor_enable,
  output logic [NUM_COUNTERS-1:0] ext_overflow_notify,
  output logic halt_all_monitors,
  output logic monitor_irq
);
  localparam int MSM_FIRST = FIRST_COUNTER + NUM_COUNTERS;

  logic [STATUS_W-1:0] status;
  logic irq_pending;
  wire [STATUS_W-1:0] next_status;
  wire [STATUS_W-1:0] hw_set;
  wire [STATUS_W-1:0] impl_mask;
  wire [NUM_COUNTERS-1:0] ovf;
  wire [NUM_COUNTERS-1:0] ovf_irq;
  wire [NUM_COUNTERS-1:0] ovf_ext;
  wire [NUM_COUNTERS-1:0] read_ok;
  wire [NUM_MSM-1:0] msm_fire;
  wire [DATA_W-1:0] cfg_chain [NUM_COUNTERS+1];
  wire [DATA_W-1:0] dat_chain [NUM_COUNTERS+1];
  wire halt;
  wire halt_set;
  wire irq_fire;
  wire status_hit;
  wire cfg_wr;
  wire dat_wr;
  wire level_zero;
  wire [DATA_W-1:0] status_word;
  wire [DATA_W-1:0] next_rd_data;

  //////////////////////////////////////////////////////////////////////////////
  // Access decode.

  assign cfg_wr = reg_wr_en & (reg_space == SPACE_CONFIG);
  assign dat_wr = reg_wr_en & (reg_space == SPACE_DATA);
  assign status_hit = (reg_index < INDEX_W'(STATUS_REGS));
  assign level_zero = (current_priv_level == PRIV_LEVEL_0);
  assign halt = status[HALT_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Counter slices and their enable and read gating.

  counter_if links [NUM_COUNTERS] ();

  assign cfg_chain[0] = ZERO_WORD;
  assign dat_chain[0] = ZERO_WORD;

  for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
    wire idx_hit;
    assign idx_hit = (reg_index == INDEX_W'(FIRST_COUNTER + i));
    assign links[i].cfg_we = cfg_wr & idx_hit;
    assign links[i].dat_we = dat_wr & idx_hit;
    assign links[i].wdata = reg_wdata;
    assign links[i].halt = halt;
    assign links[i].user_run = user_monitor_run;
    assign links[i].priv_run = priv_monitor_run;
    assign links[i].priv_level = current_priv_level;
    assign links[i].event_hit = event_pulse[i];
    assign monitor_enable[i] = links[i].enable;
    assign ovf[i] = links[i].overflow;
    assign ovf_irq[i] = links[i].overflow & links[i].irq_en;
    assign ovf_ext[i] = links[i].overflow & links[i].ext_vis;
    // User monitors read freely unless secured; privileged ones only at level zero.
    assign read_ok[i] = level_zero |
                        (~links[i].priv & ~secure_user_monitors);
    assign cfg_chain[i+1] = cfg_chain[i] |
                            (idx_hit ? links[i].config_value : ZERO_WORD);
    assign dat_chain[i+1] = dat_chain[i] |
                            ((idx_hit & read_ok[i]) ? links[i].data_value : ZERO_WORD);

    counter_slice #(
      .COUNT_W(COUNT_W)
    ) u_slice (
      .ref_clk(ref_clk),
      .reset(reset),
      .link(links[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Overflow status bits, halt bit and their sticky update.

  assign msm_fire = msm_irq_event & {NUM_MSM{~halt}};
  assign halt_set = (|ovf_irq) | (|msm_fire);
  assign irq_fire = halt_set;

  for (genvar b = 0; b < STATUS_W; b++) begin : g_bit
    wire wr_bit;
    assign wr_bit = cfg_wr & status_hit &
                    (reg_index[WORD_SEL_W-1:0] == WORD_SEL_W'(b / STATUS_WORD_W));
    if (b == HALT_BIT) begin : g_halt
      assign impl_mask[b] = 1'b1;
      assign hw_set[b] = halt_set;
    end else if (b >= FIRST_COUNTER && b < MSM_FIRST) begin : g_gen
      assign impl_mask[b] = 1'b1;
      assign hw_set[b] = ovf[b - FIRST_COUNTER];
    end else if (b >= MSM_FIRST && b < MSM_FIRST + NUM_MSM) begin : g_msm
      assign impl_mask[b] = 1'b1;
      assign hw_set[b] = msm_fire[b - MSM_FIRST];
    end else begin : g_none
      assign impl_mask[b] = 1'b0;
      assign hw_set[b] = 1'b0;
    end
    // Software may clear or set; a hardware set in the same cycle still lands.
    assign next_status[b] = ((wr_bit ? reg_wdata[b % STATUS_WORD_W] : status[b]) &
                            impl_mask[b]) | hw_set[b];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign halt_all_monitors = halt;

  //////////////////////////////////////////////////////////////////////////////
  // Monitor interrupt level and external overflow notification.

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_pending <= 1'b0;
    end else if (irq_fire & ~overflow_irq_mask) begin
      irq_pending <= 1'b1;
    end else if (irq_pend_ack | overflow_irq_mask) begin
      irq_pending <= 1'b0;
    end
  end

  assign monitor_irq = irq_pending;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ext_overflow_notify <= '0;
    end else begin
      ext_overflow_notify <= ovf_ext;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read port.

  assign status_word = status[reg_index[WORD_SEL_W-1:0] * STATUS_WORD_W +: STATUS_WORD_W];
  assign next_rd_data = (reg_space == SPACE_CONFIG) ?
                        (status_hit ? status_word : cfg_chain[NUM_COUNTERS]) :
                        dat_chain[NUM_COUNTERS];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rd_data <= ZERO_WORD;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= next_rd_data;
      end
    end
  end
endmodule

// file: inc/counter_if.sv
// Link between the overflow and gating logic and one generic counter slice.
`timescale 1ns/1ps
interface counter_if;
  logic cfg_we;
  logic dat_we;
  logic [63:0] wdata;
  logic halt;
  logic user_run;
  logic priv_run;
  logic [1:0] priv_level;
  logic event_hit;
  logic enable;
  logic overflow;
  logic irq_en;
  logic ext_vis;
  logic priv;
  logic [63:0] data_value;
  logic [63:0] config_value;
  modport ctrl (
    output cfg_we, dat_we, wdata, halt, user_run, priv_run, priv_level, event_hit,
    input enable, overflow, irq_en, ext_vis, priv, data_value, config_value
  );
  modport slice (
    input cfg_we, dat_we, wdata, halt, user_run, priv_run, priv_level, event_hit,
    output enable, overflow, irq_en, ext_vis, priv, data_value, config_value
  );
endinterface

// file: inc/perf_mon_pkg.sv
// Shared constants for the performance monitor enable and overflow block.
package perf_mon_pkg;
  localparam int DATA_W = 64;
  localparam int INDEX_W = 8;
  localparam int STATUS_REGS = 4;
  localparam int STATUS_WORD_W = 64;
  localparam int STATUS_W = STATUS_REGS * STATUS_WORD_W;
  localparam int WORD_SEL_W = 2;
  localparam int HALT_BIT = 0;
  localparam int FIRST_COUNTER = 4;
  localparam int DEFAULT_COUNTERS = 4;
  localparam int DEFAULT_COUNT_W = 32;
  localparam int DEFAULT_MSM = 1;
  localparam int PRIV_LEVEL_W = 2;
  localparam logic [PRIV_LEVEL_W-1:0] PRIV_LEVEL_0 = 2'h0;
  localparam int PLM_LSB = 0;
  localparam int PLM_W = 4;
  localparam int EV_BIT = 4;
  localparam int OI_BIT = 5;
  localparam int PM_BIT = 6;
  localparam int ES_LSB = 8;
  localparam int ES_W = 8;
  localparam logic SPACE_CONFIG = 1'b0;
  localparam logic SPACE_DATA = 1'b1;
  localparam logic [DATA_W-1:0] ZERO_WORD = 64'h0;
endpackage
